/* File: hdl/message_store.sv */
// Character store for all messages, registered read
`timescale 1ns/1ns
`include "omd_map.svh"
module message_store #(
  parameter int AW    = 11,
  parameter int DEPTH = 2000
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          ce,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  if (DEPTH < 1 || DEPTH > 2**AW) begin : g_bad
    $error("Store depth does not fit address");
  end

  logic [7:0] mem [DEPTH];

  // No reset: contents are loaded by editing, read data is masked until then
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en && wr_addr < AW'(DEPTH)) mem[wr_addr] <= wr_data;
      rd_data <= (rd_addr < AW'(DEPTH)) ? mem[rd_addr] : `CH_SPACE;
    end
  end
endmodule

/* File: hdl/omd_map.svh */
// Codes, limits and timing figures for the output message display control
// Notes on behaviour
// (R1) Each output picks off, restore or on
// (R2) Restore reapplies saved state, never timed outputs
// (R3) Forced states are logical, phase sets level
// (R4) Reset-with-count on: value reset clears output
// (R5) Reset-with-count off: value reset leaves output
// (R6) Each output names a message, or none
// (R7) Request needs 50 ms continuous activation
// (R8) Four displays, each line picks content
// (R9) Label initial beside value; total unlabelled
// (R10) Peak and valley use two-letter labels
// (R11) Status shows digit when on, box when off
// (R12) Displays advance 2.5 s, 5 s or keys
// (R13) Brightness levels 1 to 5 per colour
// (R14) Ten messages from outputs, inputs or serial
// (R15) Single-line block on top, steps every 2 s
// (R16) Dual-line block uses both lines, 2 s steps
// (R17) Single-line scroll about three characters per second
// (R18) Dual-line scroll blanks the bottom line
// (R19) Type change turns markers into spaces
// (R20) Message holds 200 characters with terminator
// (R21) Marker-only blocks blank; markers inert when scrolling
// (R22) Terminating marker cannot be edited
// (R23) Priority 1 to 8; equal or higher displaces
`ifndef OMD_MAP_SVH
`define OMD_MAP_SVH
`define NUM_OUT       32'h0000_0004
`define NUM_MSG       32'h0000_000A
`define MSG_CHARS     32'h0000_00C8
`define LINE_CHARS    32'h0000_0010
`define CNT_BITS      32'h0000_001C
`define MSG_NONE      4'hF
`define PU_OFF        2'h0
`define PU_RESTORE    2'h1
`define PU_ON         2'h2
`define ADV_NONE      2'h0
`define ADV_FAST      2'h1
`define ADV_SLOW      2'h2
`define LS_LABEL      3'h0
`define LS_VALUE      3'h1
`define LS_STATUS     3'h2
`define LS_PRESET     3'h3
`define LS_LOAD       3'h4
`define LS_CUSTOM_A   3'h5
`define LS_CUSTOM_B   3'h6
`define VAL_RATE      3'h0
`define VAL_PEAK      3'h1
`define VAL_VALLEY    3'h2
`define VAL_PROCESS   3'h3
`define VAL_BATCH     3'h4
`define VAL_TOTAL     3'h5
`define CH_NUL        8'h00
`define CH_EOL        8'h01
`define CH_EOB        8'h02
`define CH_BOX        8'h03
`define CH_SPACE      8'h20
`define CH_DIGIT1     8'h31
`define LEVEL_MIN     3'h1
`define LEVEL_MAX     3'h5
`define CLK_KHZ       32'h0000_C350
`define REQ_MIN_MS    32'h0000_0032
`define BLOCK_STEP_MS 32'h0000_07D0
`define ADV_FAST_MS   32'h0000_09C4
`define ADV_SLOW_MS   32'h0000_1388
`define SCROLL_MS     32'h0000_014D
`endif

/* File: hdl/omd_pkg.sv */
// Types shared by the output message display control
package omd_pkg;
  typedef enum logic [1:0] {
    single_line_block_type,
    dual_line_block_type,
    single_line_scroll_type,
    dual_line_scroll_type
  } msg_type_t;
  typedef enum logic {eng_idle, eng_show} eng_t;
endpackage

/* File: hdl/output_message_display_control.sv */
// Output power-up, message requests, message engine and indication display control
`timescale 1ns/1ns
`include "omd_map.svh"
module output_message_display_control
  import omd_pkg::*;
#(
  parameter int NOUT         = `NUM_OUT,
  parameter int NMSG         = `NUM_MSG,
  parameter int MCHARS       = `MSG_CHARS,
  parameter int LCH          = `LINE_CHARS,
  parameter int REQ_MIN_CYC  = `REQ_MIN_MS * `CLK_KHZ,
  parameter int STEP_CYC     = `BLOCK_STEP_MS * `CLK_KHZ,
  parameter int ADV_FAST_CYC = `ADV_FAST_MS * `CLK_KHZ,
  parameter int ADV_SLOW_CYC = `ADV_SLOW_MS * `CLK_KHZ,
  parameter int SCROLL_CYC   = `SCROLL_MS * `CLK_KHZ
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  // Output control
  input  wire logic [NOUT-1:0]      out_set,
  input  wire logic [NOUT-1:0]      out_end,
  input  wire logic [NOUT-1:0]      out_timed,
  input  wire logic [NOUT-1:0]      out_neg_phase,
  input  wire logic [2*NOUT-1:0]    pu_mode,
  input  wire logic [NOUT-1:0]      saved_active,
  input  wire logic [NOUT-1:0]      reset_with_count,
  input  wire logic [2*NOUT-1:0]    out_assign,
  input  wire logic [3:0]           value_reset,
  output logic      [NOUT-1:0]      out_active,
  output logic      [NOUT-1:0]      out_drive,
  // Message requests
  input  wire logic [4*NOUT-1:0]    output_message_select,
  input  wire logic                 ext_req,
  input  wire logic [3:0]           ext_req_msg,
  input  wire logic                 msg_cancel,
  input  wire logic [2*NMSG-1:0]    msg_type,
  input  wire logic [3*NMSG-1:0]    msg_priority,
  // Message text editing
  input  wire logic                 edit_wr,
  input  wire logic [3:0]           edit_msg,
  input  wire logic [7:0]           edit_pos,
  input  wire logic [7:0]           edit_char,
  input  wire logic                 edit_len_wr,
  input  wire logic [7:0]           edit_len,
  // Indication configuration and keys
  input  wire logic [23:0]          line_sel,
  input  wire logic [23:0]          line_value,
  input  wire logic [39:0]          label_first,
  input  wire logic [1:0]           display_advance_interval,
  input  wire logic                 key_up,
  input  wire logic                 key_down,
  input  wire logic [2:0]           level_green,
  input  wire logic [2:0]           level_red,
  input  wire logic [3:0]           disp_red,
  // Display outputs, with the render line and column inputs
  output logic      [1:0]           disp_index,
  output logic      [5:0]           top_line,
  output logic      [5:0]           bottom_line,
  output logic      [15:0]          top_prefix,
  output logic      [15:0]          bottom_prefix,
  output logic      [8*NOUT-1:0]    status_chars,
  output logic      [2:0]           intensity,
  output logic                      top_from_msg,
  output logic                      bottom_from_msg,
  output logic                      bottom_blank,
  output logic      [3:0]           msg_num,
  input  wire logic                 render_line,
  input  wire logic [$clog2(LCH)-1:0] render_col,
  output logic      [7:0]           render_char
);
  localparam int CW = `CNT_BITS;
  localparam int AW = $clog2(NMSG * MCHARS);

  if (NOUT < 1 || NOUT > 9 || NMSG < 1 || NMSG > 15 || MCHARS > 255 || LCH < 1
      || REQ_MIN_CYC < 1 || STEP_CYC < 1 || ADV_FAST_CYC < 1 || SCROLL_CYC < 1
      || ADV_SLOW_CYC < 1 || ADV_SLOW_CYC >= 2**CW || STEP_CYC >= 2**CW) begin : g_bad
    $error("Unsupported parameter set");
  end

  // Reset release through two flops
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Panel keys come from pins: two flops, then a third for edges
  logic [2:0] up_s, dn_s;
  logic       up_edge, dn_edge;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_s <= 3'h0;
      dn_s <= 3'h0;
    end else if (ce) begin
      up_s <= {up_s[1:0], key_up};
      dn_s <= {dn_s[1:0], key_down};
    end
  end
  assign up_edge = up_s[1] & ~up_s[2];
  assign dn_edge = dn_s[1] & ~dn_s[2];

  function automatic [2:0] prio_of(input [3:0] m);
    prio_of = msg_priority[3*m +: 3];
  endfunction

  function automatic [AW-1:0] mem_addr(input [3:0] m, input [8:0] p);
    mem_addr = AW'(m * MCHARS + p);
  endfunction

  function automatic [2:0] clamp_level(input [2:0] l);
    clamp_level = (l < `LEVEL_MIN) ? `LEVEL_MIN : (l > `LEVEL_MAX) ? `LEVEL_MAX : l;
  endfunction

  // Label beside a numeric value; no room for it when the value is the total
  function automatic [15:0] prefix_of(input [2:0] sel, input [2:0] val, input [2:0] other);
    prefix_of = {`CH_SPACE, `CH_SPACE};
    if (sel == `LS_VALUE && other != `LS_LABEL) begin
      case (val)
        `VAL_RATE, `VAL_PROCESS, `VAL_BATCH: prefix_of = {label_first[8*val +: 8], `CH_SPACE};
        `VAL_PEAK:   prefix_of = {label_first[7:0], label_first[15:8]}; // R10
        `VAL_VALLEY: prefix_of = {label_first[7:0], label_first[23:16]}; // R10
        `VAL_TOTAL:  prefix_of = {`CH_NUL, `CH_NUL}; // R9
        default:     prefix_of = {`CH_SPACE, `CH_SPACE};
      endcase
    end
  endfunction

  // Output states: power-up choice first, manual reset beats a new set
  logic [NOUT-1:0] next_active, next_drive, rst_hit;
  logic            pu_done, next_pu_done;
  always_comb begin
    next_active  = out_active;
    next_pu_done = 1'b1;
    for (int i = 0; i < NOUT; i++) begin
      rst_hit[i] = value_reset[out_assign[2*i +: 2]] & reset_with_count[i]; // R4 R5
      if (!pu_done) begin
        case (pu_mode[2*i +: 2]) // R1
          `PU_ON:      next_active[i] = 1'b1;
          `PU_RESTORE: next_active[i] = saved_active[i] & ~out_timed[i]; // R2
          default:     next_active[i] = 1'b0;
        endcase
      end else if (rst_hit[i]) next_active[i] = 1'b0; // R4
      else if (out_set[i]) next_active[i] = 1'b1;
      else if (out_end[i]) next_active[i] = 1'b0;
    end
    next_drive = next_active ^ out_neg_phase; // R3
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_active <= '0;
      out_drive  <= '0;
      pu_done    <= 1'b0;
    end else if (ce) begin
      out_active <= next_active;
      out_drive  <= next_drive;
      pu_done    <= next_pu_done;
    end
  end

  // Activation timers; a request fires once the output has held for the minimum
  logic [CW-1:0]   act_cnt [NOUT];
  logic [CW-1:0]   next_act_cnt [NOUT];
  logic [NOUT-1:0] out_fire;
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      if (!out_active[i]) next_act_cnt[i] = '0;
      else if (act_cnt[i] == CW'(REQ_MIN_CYC)) next_act_cnt[i] = act_cnt[i];
      else next_act_cnt[i] = act_cnt[i] + 1'b1;
      out_fire[i] = out_active[i] && act_cnt[i] == CW'(REQ_MIN_CYC - 1) // R7
                    && output_message_select[4*i +: 4] != `MSG_NONE; // R6
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NOUT; i++) act_cnt[i] <= '0;
    end else if (ce) begin
      act_cnt <= next_act_cnt;
    end
  end

  // Request pick: external sources first, then outputs in number order
  logic       req_hit;
  logic [3:0] req_msg;
  always_comb begin
    req_hit = 1'b0;
    req_msg = 4'h0;
    for (int i = NOUT - 1; i >= 0; i--) begin
      if (out_fire[i] && output_message_select[4*i +: 4] < NMSG) begin // R14
        req_hit = 1'b1;
        req_msg = output_message_select[4*i +: 4];
      end
    end
    if (ext_req && ext_req_msg < NMSG) begin // R14
      req_hit = 1'b1;
      req_msg = ext_req_msg;
    end
  end

  // Message lengths; the terminator sits at the length and is never stored
  logic [7:0] msg_len [NMSG];
  logic [7:0] next_msg_len [NMSG];
  logic [7:0] edit_cur_len;
  logic       mem_we;
  always_comb begin
    next_msg_len = msg_len;
    edit_cur_len = (edit_msg < NMSG) ? msg_len[edit_msg] : 8'h00;
    if (edit_len_wr && edit_msg < NMSG && edit_len < MCHARS) // R20
      next_msg_len[edit_msg] = edit_len;
    mem_we = edit_wr && edit_msg < NMSG && edit_pos < edit_cur_len; // R22
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NMSG; i++) msg_len[i] <= 8'h00;
    end else if (ce) begin
      msg_len <= next_msg_len;
    end
  end

  // Message engine: shown message, block or scroll position, step timer
  eng_t          eng, next_eng;
  logic [3:0]    next_msg_num;
  logic [2:0]    shown_prio, next_shown_prio;
  logic [7:0]    offset, next_offset;
  logic [CW-1:0] eng_tmr, next_eng_tmr;
  logic [8:0]    step_pos;
  msg_type_t     shown_type;
  logic [7:0]    shown_len;
  logic          is_scroll, is_dual;
  assign shown_type = msg_type_t'(msg_type[2*msg_num +: 2]);
  assign shown_len  = msg_len[msg_num];
  assign is_scroll  = shown_type inside {single_line_scroll_type, dual_line_scroll_type};
  assign is_dual    = shown_type == dual_line_block_type;
  always_comb begin
    next_eng        = eng;
    next_msg_num    = msg_num;
    next_shown_prio = shown_prio;
    next_offset     = offset;
    next_eng_tmr    = eng_tmr + 1'b1;
    step_pos        = {1'b0, offset} + 9'(is_dual ? 2 * LCH : LCH);
    case (eng)
      eng_idle: begin
        next_eng_tmr = '0;
        if (req_hit && !msg_cancel) begin
          next_eng        = eng_show;
          next_msg_num    = req_msg;
          next_shown_prio = prio_of(req_msg);
          next_offset     = 8'h00;
        end
      end
      eng_show: begin
        if (msg_cancel) begin
          next_eng = eng_idle;
        end else if (req_hit && prio_of(req_msg) <= shown_prio) begin // R23
          next_msg_num    = req_msg;
          next_shown_prio = prio_of(req_msg);
          next_offset     = 8'h00;
          next_eng_tmr    = '0;
        end else if (eng_tmr >= CW'((is_scroll ? SCROLL_CYC : STEP_CYC) - 1)) begin
          next_eng_tmr = '0;
          if (is_scroll) next_offset = (offset < shown_len) ? offset + 8'h01 : 8'h00; // R17
          else next_offset = (step_pos < {1'b0, shown_len}) ? step_pos[7:0] : 8'h00; // R15 R16
        end
      end
      default: next_eng = eng_idle;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng        <= eng_idle;
      msg_num    <= 4'h0;
      shown_prio <= 3'h0;
      offset     <= 8'h00;
      eng_tmr    <= '0;
    end else if (ce) begin
      eng        <= next_eng;
      msg_num    <= next_msg_num;
      shown_prio <= next_shown_prio;
      offset     <= next_offset;
      eng_tmr    <= next_eng_tmr;
    end
  end
  // Single-line types leave the bottom line on the indication display
  assign top_from_msg    = eng == eng_show; // R15 R17
  assign bottom_from_msg = eng == eng_show && is_dual; // R16
  assign bottom_blank    = eng == eng_show && shown_type == dual_line_scroll_type; // R18

  // Render pipe: store read, then marker and end substitution
  logic [8:0] rd_pos;
  logic [7:0] rd_data, next_render;
  logic       past_q, next_past;
  always_comb begin
    rd_pos = {1'b0, offset} + 9'(render_col);
    if (render_line && is_dual) rd_pos = rd_pos + 9'(LCH); // R16
    next_past = rd_pos >= {1'b0, shown_len};
    // Markers only shape blocks, so any type shows them as blank space
    if (past_q || rd_data == `CH_EOL || rd_data == `CH_EOB) next_render = `CH_SPACE; // R19 R21
    else next_render = rd_data;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      past_q      <= 1'b1;
      render_char <= `CH_SPACE;
    end else if (ce) begin
      past_q      <= next_past;
      render_char <= next_render;
    end
  end

  message_store #(.AW(AW), .DEPTH(NMSG * MCHARS)) i_message_store (
    .clk     (clk),
    .ce      (ce),
    .wr_en   (mem_we),
    .wr_addr (mem_addr(edit_msg, {1'b0, edit_pos})),
    .wr_data (edit_char),
    .rd_addr (mem_addr(msg_num, next_past ? 9'h000 : rd_pos)),
    .rd_data (rd_data)
  );

  // Indication display stepping and line contents
  logic [1:0]        next_disp_index;
  logic [CW-1:0]     adv_tmr, next_adv_tmr;
  logic [5:0]        next_top, next_bottom;
  logic [15:0]       next_top_prefix, next_bottom_prefix;
  logic [8*NOUT-1:0] next_status;
  logic [2:0]        next_intensity;
  always_comb begin
    next_disp_index = disp_index;
    next_adv_tmr    = adv_tmr + 1'b1;
    if (up_edge) begin
      next_disp_index = disp_index + 2'h1; // R12
      next_adv_tmr    = '0;
    end else if (dn_edge) begin
      next_disp_index = disp_index - 2'h1; // R12
      next_adv_tmr    = '0;
    end else if (display_advance_interval == `ADV_NONE) begin
      next_adv_tmr = '0;
    end else if (adv_tmr == CW'((display_advance_interval == `ADV_FAST)
                                ? ADV_FAST_CYC - 1 : ADV_SLOW_CYC - 1)) begin
      next_disp_index = disp_index + 2'h1; // R12
      next_adv_tmr    = '0;
    end
    next_top    = {line_value[6*disp_index +: 3], line_sel[6*disp_index +: 3]}; // R8
    next_bottom = {line_value[6*disp_index+3 +: 3], line_sel[6*disp_index+3 +: 3]}; // R8
    next_top_prefix    = prefix_of(next_top[2:0], next_top[5:3], next_bottom[2:0]); // R9
    next_bottom_prefix = prefix_of(next_bottom[2:0], next_bottom[5:3], next_top[2:0]); // R9
    for (int i = 0; i < NOUT; i++)
      next_status[8*i +: 8] = out_active[i] ? 8'(`CH_DIGIT1 + i) : `CH_BOX; // R11
    next_intensity = disp_red[disp_index] ? clamp_level(level_red)
                                          : clamp_level(level_green); // R13
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_index    <= 2'h0;
      adv_tmr       <= '0;
      top_line      <= 6'h00;
      bottom_line   <= 6'h00;
      top_prefix    <= {`CH_SPACE, `CH_SPACE};
      bottom_prefix <= {`CH_SPACE, `CH_SPACE};
      status_chars  <= {NOUT{`CH_BOX}};
      intensity     <= `LEVEL_MAX;
    end else if (ce) begin
      disp_index    <= next_disp_index;
      adv_tmr       <= next_adv_tmr;
      top_line      <= next_top;
      bottom_line   <= next_bottom;
      top_prefix    <= next_top_prefix;
      bottom_prefix <= next_bottom_prefix;
      status_chars  <= next_status;
      intensity     <= next_intensity;
    end
  end

  // Power-up targets of every output, so the checks cover all of them at once
  logic [NOUT-1:0] pu_on_mask, pu_timed_mask;
  always_comb begin
    for (int i = 0; i < NOUT; i++) begin
      pu_on_mask[i]    = pu_mode[2*i +: 2] == `PU_ON;
      pu_timed_mask[i] = pu_mode[2*i +: 2] == `PU_RESTORE && out_timed[i];
    end
  end

  // Checks on the outputs, the engine, message editing and the indication display
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_drive_phase: assert property (ce |=> out_drive == (out_active ^ $past(out_neg_phase))) // R3
    else $error("Drive level does not follow phase");
  a_powerup_on: assert property ($rose(pu_done) // R1
      |-> (out_active & $past(pu_on_mask)) == $past(pu_on_mask))
    else $error("Forced-on output is off after power-up");
  a_restore_timed: assert property ($rose(pu_done) // R2
      |-> (out_active & $past(pu_timed_mask)) == '0)
    else $error("Timed output restored active");
  a_reset_count: assert property (ce && pu_done && rst_hit != '0 // R4
      |=> (out_active & $past(rst_hit)) == '0)
    else $error("Output kept after value reset");
  a_reset_kept: assert property (ce && pu_done && !reset_with_count[0] && !out_set[0] // R5
      && !out_end[0] |=> $stable(out_active[0]))
    else $error("Output changed without cause");
  a_fire_held: assert property (out_fire[0] |-> out_active[0] && act_cnt[0] >= CW'(REQ_MIN_CYC - 1) // R7
      && output_message_select[3:0] != `MSG_NONE)
    else $error("Request raised without long enough activation");
  a_prio_hold: assert property (ce && eng == eng_show && !msg_cancel && req_hit // R23
      && prio_of(req_msg) > shown_prio |=> msg_num == $past(msg_num))
    else $error("Lower priority message displaced the shown one");
  a_end_locked: assert property (edit_wr && edit_pos >= edit_cur_len |-> !mem_we) // R22
    else $error("Terminator position written");
  a_len_bound: assert property (edit_cur_len < 8'(MCHARS)) // R20
    else $error("Message length beyond store");
  a_bottom_blank: assert property (eng == eng_show && shown_type == dual_line_scroll_type // R18
      |-> bottom_blank && !bottom_from_msg)
    else $error("Bottom line not blanked for dual scroll");
  a_level_range: assert property (intensity >= `LEVEL_MIN && intensity <= `LEVEL_MAX) // R13
    else $error("Brightness outside levels");
  a_status_box: assert property (ce |=> status_chars[7:0] // R11
      == ($past(out_active[0]) ? `CH_DIGIT1 : `CH_BOX))
    else $error("Status character wrong");
  a_key_step: assert property (ce && up_edge |=> disp_index == 2'($past(disp_index) + 2'h1)) // R12
    else $error("Up key did not advance the display");

  c_restore_on: cover property ($rose(pu_done) && out_active[0]);
  c_msg_shown: cover property (eng == eng_idle ##1 eng == eng_show);
  c_replaced: cover property (eng == eng_show && req_hit && !msg_cancel ##1 eng == eng_show);
  c_auto_step: cover property (ce && display_advance_interval == `ADV_FAST && adv_tmr == '0
      && $past(adv_tmr) != '0);
endmodule

/* File: verif/output_message_display_control_tb.sv */
// Self-checking bench for the output message display control
`timescale 1ns/1ns
module output_message_display_control_tb;
  logic        clk, reset_n, ce, render_line, ext_req, msg_cancel, key_up, key_down, press_up;
  logic        edit_wr, edit_len_wr, top_from_msg, bottom_from_msg, bottom_blank, press_down;
  logic [3:0]  out_set, out_end, out_timed, out_neg_phase, saved_active, reset_with_count;
  logic [3:0]  value_reset, ext_req_msg, edit_msg, disp_red, msg_num, out_active, out_drive;
  logic [7:0]  pu_mode, out_assign, edit_pos, edit_char, edit_len, render_char;
  logic [15:0] output_message_select, top_prefix;
  logic [19:0] msg_type;
  logic [29:0] msg_priority;
  logic [23:0] line_sel, line_value;
  logic [39:0] label_first;
  logic [2:0]  level_green, level_red, intensity;
  logic [1:0]  display_advance_interval, disp_index;
  logic [31:0] status_chars;
  logic [3:0]  render_col;
  logic [5:0]  top_line;
  int          failures, total_checks;
  logic [7:0]  col_exp [3] = '{8'h41, 8'h20, 8'h20};
  logic [11:0] lvl [3] = '{12'he55, 12'h051, 12'h2b3};

  output_message_display_control #(.REQ_MIN_CYC(8), .STEP_CYC(40), .ADV_FAST_CYC(30),
    .ADV_SLOW_CYC(60), .SCROLL_CYC(10)) i_output_message_display_control (
    .clk, .reset_n, .ce, .out_set, .out_end, .out_timed, .out_neg_phase, .pu_mode,
    .saved_active, .reset_with_count, .out_assign, .value_reset, .out_active, .out_drive,
    .output_message_select, .ext_req, .ext_req_msg, .msg_cancel, .msg_type, .msg_priority,
    .edit_wr, .edit_msg, .edit_pos, .edit_char, .edit_len_wr, .edit_len, .line_sel,
    .line_value, .label_first, .display_advance_interval, .key_up, .key_down, .level_green,
    .level_red, .disp_red, .disp_index, .top_line, .bottom_line(), .top_prefix,
    .bottom_prefix(), .status_chars, .intensity, .top_from_msg, .bottom_from_msg,
    .bottom_blank, .msg_num, .render_line, .render_col, .render_char);

  panel_model i_panel_model (.clk, .press_up, .press_down, .key_up, .key_down);

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Pulse a request from the user inputs, then sample after it lands
  task automatic req(input logic [3:0] m);
    @(posedge clk) ext_req <= 1'b1;
    ext_req_msg <= m;
    @(posedge clk) ext_req <= 1'b0;
    @(negedge clk);
  endtask

  task automatic cancel();
    @(posedge clk) msg_cancel <= 1'b1;
    @(posedge clk) msg_cancel <= 1'b0;
    @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    cyc(3000);
    failures++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0; ce = 1'b1; render_line = 1'b0; ext_req = 1'b0; msg_cancel = 1'b0;
    press_up = 1'b0; edit_wr = 1'b0; edit_len_wr = 1'b0; out_set = '0; out_end = '0;
    pu_mode = 8'h64; saved_active = 4'b1010; out_timed = 4'b1000; out_neg_phase = 4'b0100;
    reset_with_count = 4'b0010; out_assign = '0; value_reset = '0; ext_req_msg = '0;
    output_message_select = 16'hfff7; msg_type = '0; msg_priority = 30'h0001_5400;
    edit_msg = '0; edit_pos = '0; edit_char = '0; edit_len = '0; line_sel = '0;
    line_value = '0; label_first = '0; display_advance_interval = '0; level_green = 3'h5;
    level_red = 3'h5; disp_red = '0; render_col = '0; failures = 0; total_checks = 0;
    press_down = 1'b0;
    cyc(8);
    reset_n <= 1'b1;
    cyc(5);
    @(negedge clk);
    chk(out_active, 32'h6);
    chk(out_drive, 32'h2);
    chk(status_chars, 32'h0333_3203);
    @(posedge clk) value_reset <= 4'h1;
    @(posedge clk) value_reset <= 4'h0;
    @(negedge clk) chk(out_active, 32'h4);
    req(4'h3);
    chk(msg_num, 32'h3);
    req(4'h4);
    chk(msg_num, 32'h3);
    req(4'h5);
    chk(msg_num, 32'h5);
    cancel();
    // Short activation must not raise a request
    @(posedge clk) out_set <= 4'h1;
    @(posedge clk) out_set <= 4'h0;
    cyc(3);
    out_end <= 4'h1;
    @(posedge clk) out_end <= 4'h0;
    cyc(12);
    @(negedge clk) chk(top_from_msg, 32'h0);
    @(posedge clk) out_set <= 4'h1;
    @(posedge clk) out_set <= 4'h0;
    cyc(12);
    @(negedge clk) chk(msg_num, 32'h7);
    chk(top_from_msg, 32'h1);
    // Two-character text with an end-of-block marker after the letter
    @(posedge clk) edit_len_wr <= 1'b1;
    edit_msg <= 4'h3;
    edit_len <= 8'h02;
    @(posedge clk) edit_len_wr <= 1'b0;
    edit_wr <= 1'b1;
    edit_char <= 8'h41;
    @(posedge clk) edit_pos <= 8'h01;
    edit_char <= 8'h02;
    @(posedge clk) edit_wr <= 1'b0;
    cancel();
    req(4'h3);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk) render_col <= 4'(c);
      cyc(3);
      @(negedge clk) chk(render_char, col_exp[c]);
    end
    @(posedge clk) msg_type <= 20'h0_0040;
    @(negedge clk) chk(bottom_from_msg, 32'h1);
    @(posedge clk) msg_type <= 20'h0_00c0;
    @(negedge clk) chk(bottom_blank, 32'h1);
    chk(bottom_from_msg, 32'h0);
    @(posedge clk) press_up <= 1'b1;
    @(posedge clk) press_up <= 1'b0;
    cyc(8);
    @(negedge clk) chk(disp_index, 32'h1);
    // Clock enable low freezes the advance timer for five edges
    @(posedge clk) display_advance_interval <= 2'h1;
    ce <= 1'b0;
    cyc(5);
    ce <= 1'b1;
    cyc(29);
    @(negedge clk) chk(disp_index, 32'h1);
    @(negedge clk) chk(disp_index, 32'h2);
    @(posedge clk) display_advance_interval <= 2'h0;
    @(posedge clk) press_down <= 1'b1;
    @(posedge clk) press_down <= 1'b0;
    cyc(8);
    @(negedge clk) chk(disp_index, 32'h1);
    // Green levels are clamped into the legal span from both ends; red is taken in range
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) level_green <= lvl[i][11:9];
      level_red <= lvl[i][6:4];
      disp_red <= {4{lvl[i][7]}};
      cyc(3);
      @(negedge clk) chk(intensity, lvl[i][2:0]);
    end
    // Peak value gets two initials; the total gets no label column
    @(posedge clk) line_sel <= 24'h00_0440;
    line_value <= 24'h00_0040;
    label_first <= 40'h00_0000_5052;
    cyc(2);
    @(negedge clk) chk(top_line, 32'h9);
    chk(top_prefix, 32'h5250);
    @(posedge clk) line_value <= 24'h00_0140;
    cyc(2);
    @(negedge clk) chk(top_prefix, 32'h0);
    tally_and_finish();
  end
endmodule

/* File: verif/panel_model.sv */
// Front panel keypad model that holds an arrow key down for several clocks
`timescale 1ns/1ns
module panel_model (
  // Clock
  input  wire logic clk,
  // Bench commands
  input  wire logic press_up,
  input  wire logic press_down,
  // Key pins
  output logic      key_up,
  output logic      key_down
);
  logic [2:0] hold = 3'h0;
  logic       down = 1'b0;
  // A real key stays down well past the synchroniser depth, then lets go
  always @(posedge clk) begin
    if (press_up || press_down) begin
      hold <= 3'h6;
      down <= press_down;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign key_up   = (hold != 3'h0) && !down;
  assign key_down = (hold != 3'h0) && down;
endmodule
